// *** sim/spr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module spr_host (
  // bus lines
  input wire logic clock_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask : clk
  // sda only moves while scl low; sample late in high phase
  task automatic bit_x(input logic b, output logic s);
    sda_o = b;
    clk(2);
    scl_o = 1'b1;
    clk(3);
    s = sda_i;
    scl_o = 1'b0;
    clk(2);
  endtask : bit_x
  // works from idle and as repeated start
  task automatic start;
    sda_o = 1'b1;
    clk(2);
    scl_o = 1'b1;
    clk(3);
    sda_o = 1'b0;
    clk(3);
    scl_o = 1'b0;
    clk(2);
  endtask : start
  task automatic stop;
    sda_o = 1'b0;
    clk(2);
    scl_o = 1'b1;
    clk(3);
    sda_o = 1'b1;
    clk(3);
  endtask : stop
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, ack);
  endtask : tx
  task automatic rx(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nak, s);
  endtask : rx
  task automatic write_reg(input logic [6:0] a, input logic [7:0] r, d, output logic [2:0] k);
    start();
    tx({a, 1'b0}, k[2]);
    tx(r, k[1]);
    tx(d, k[0]);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                          output logic [2:0] k);
    start();
    tx({a, 1'b0}, k[2]);
    tx(r, k[1]);
    start();
    tx({a, 1'b1}, k[0]);
    rx(1'b1, d);
    stop();
  endtask : read_reg
  // host ack asks for the same register again, then nack
  task automatic read_twice(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d0, d1,
                            output logic [2:0] k);
    start();
    tx({a, 1'b0}, k[2]);
    tx(r, k[1]);
    start();
    tx({a, 1'b1}, k[0]);
    rx(1'b0, d0);
    rx(1'b1, d1);
    stop();
  endtask : read_twice
endmodule : spr_host
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
  import spr_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h1D;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl, host_sda, dut_sda, dut_oe_n, wr_stb, rd_shared;
  logic [7:0] rd_addr, rdv;
  logic [3:0] rd_chan;
  logic [2:0] acks;
  spr_wr_t wr, last_wr;
  int n_errors = 0, cmp_count = 0, n_stb = 0, n0;
  logic [31:0] rnd = 32'h024444DA;
  logic [15:0] cs;
  logic [7:0] pg, ra, d;
  logic [7:0] pages [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
  logic [7:0] regs [4] = '{8'h02, 8'h05, 8'h10, 8'h06};
  wire logic sda_w = host_sda & (dut_oe_n | dut_sda);
  wire logic [7:0] rd_data = rd_addr ^ (rd_shared ? 8'hA5 : {4'h0, rd_chan});
  always #5 clock_i = ~clock_i;
  // sampled away from the edge that launches the strobe
  always @(negedge clock_i) if (wr_stb === 1'b1)
  begin
    n_stb++;
    last_wr = wr;
  end
  spr_host host_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  spr_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n), .dev_addr_i(ADDR), .wr_stb_o(wr_stb), .wr_o(wr),
    .rd_addr_o(rd_addr), .rd_shared_o(rd_shared), .rd_chan_o(rd_chan), .rd_data_i(rd_data));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic spr_wr_t ew(input logic [7:0] p, input logic [15:0] c, input logic [7:0] r, v);
    ew.shared = ~p[0];
    ew.mask = !p[0] ? 16'h0000 : (p[1] ? 16'hFFFF : c);
    ew.addr = r;
    ew.data = v;
  endfunction : ew
  function automatic logic [7:0] er(input logic [7:0] p, input logic [15:0] c, input logic [7:0] r);
    if (!p[0]) return r ^ 8'hA5;
    if ($countones(c) != 1) return 8'h00;
    return r ^ 8'($clog2(c));
  endfunction : er
  task automatic check(input string nm, input logic [32:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : check
  task automatic wrr(input logic [7:0] r, v);
    host_u.write_reg(ADDR, r, v, acks);
    check("write acks", 3'b000, acks);
  endtask : wrr
  task automatic rdr(input logic [7:0] r);
    host_u.read_reg(ADDR, r, rdv, acks);
    check("read acks", 3'b000, acks);
  endtask : rdr
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial
  begin
    #800000;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge clock_i);
    @(negedge clock_i) resetn_i = 1'b1;
    check("shared sel", 1'b1, rd_shared);
    host_u.clk(2);
    rdr(REG_CSEL_LO);
    check("csel lo reset", 8'h00, rdv);
    rdr(REG_CSEL_HI);
    check("csel hi reset", 8'h00, rdv);
    rdr(REG_PAGE);
    check("page reset", 8'h00, rdv);
    $display("test reset done");
    wrr(REG_PAGE, 8'hFF);
    rdr(REG_PAGE);
    check("page unused bits", 8'h03, rdv);
    check("global no strobe", 0, n_stb);
    $display("test page done");
    for (int i = 0; i < 16; i++)
    begin
      rnd = xs(rnd);
      cs = rnd[0] ? 16'(1) << rnd[7:4] : rnd[31:16];
      rnd = xs(rnd);
      pg = pages[rnd[1:0]];
      ra = regs[rnd[3:2]];
      d = rnd[15:8];
      if (i == 0) {cs, pg} = {16'h8000, 8'h03};
      if (i == 1) {cs, pg} = {16'h0000, 8'h01};
      wrr(REG_CSEL_LO, cs[7:0]);
      wrr(REG_CSEL_HI, cs[15:8]);
      wrr(REG_PAGE, pg);
      n0 = n_stb;
      wrr(ra, d);
      check("strobe count", n0 + 1, n_stb);
      check("write bundle", ew(pg, cs, ra, d), last_wr);
      rdr(ra);
      check("read data", er(pg, cs, ra), rdv);
      rdr(REG_CSEL_HI);
      check("csel hi any page", cs[15:8], rdv);
    end
    $display("test routing done");
    wrr(REG_CSEL_LO, 8'h00);
    wrr(REG_CSEL_HI, 8'h04);
    wrr(REG_PAGE, 8'h03);
    host_u.read_twice(ADDR, 8'h06, rdv, d, acks);
    check("repeat acks", 3'b000, acks);
    check("repeat first", er(8'h03, 16'h0400, 8'h06), rdv);
    check("repeat second", er(8'h03, 16'h0400, 8'h06), d);
    n0 = n_stb;
    wrr(8'h06, rdv ^ 8'h3C);
    check("rmw strobe", n0 + 1, n_stb);
    check("rmw bundle", ew(8'h03, 16'h0400, 8'h06, rdv ^ 8'h3C), last_wr);
    $display("test repeat done");
    n0 = n_stb;
    host_u.write_reg(ADDR ^ 7'h01, 8'h02, 8'h11, acks);
    check("foreign address", 3'b111, acks);
    check("foreign no strobe", n0, n_stb);
    $display("test foreign done");
    conclude();
  end
endmodule : tb
`default_nettype wire

// *** verilog/spr_pkg.sv ***
// Functional notes
// R1 - Host writes: START, write address, register address byte, data byte.
// R2 - Device acknowledges every byte of a register write transaction.
// R3 - Configuration accepted any time after power up, channels independently.
// R4 - Globals at channel_select_low, channel_select_high, page_and_broadcast_select reachable on every page.
// R5 - Select bit set to 1 selects a channel; writes update all selected.
// R6 - Low select maps channels 7..0, high select channels 15..8.
// R7 - Channel read with more than one channel selected returns 0x00.
// R8 - Page bit 0: 1 routes to channel registers, 0 to shared registers.
// R9 - Page bits 1 and 0 set broadcast writes to all sixteen channels.
// R10 - Page 0x03 with one channel: reads that channel, writes go to all.
// R11 - Page register bits 7..2 reset to and read as zero.
// R12 - Bits honour access class: read-only, read/write, write-only, self-clearing.
// R13 - Shared registers affect all channels; channel registers only their own.
// R14 - Host changes part of a register by read-modify-write.
// R15 - Host does not write undocumented reserved locations.
// R16 - Address LSB is 0 for write and 1 for read.
// R17 - Read: address, register byte, repeated START, read address, data, NACK.
// R18 - Channel mask and page bits reset to zero after power-on.
package spr_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_IDX_W = 4;
  localparam logic [7:0] REG_CSEL_LO = 8'hFC;
  localparam logic [7:0] REG_CSEL_HI = 8'hFD;
  localparam logic [7:0] REG_PAGE = 8'hFF;
  localparam int PAGE_CH_BIT = 0;
  localparam int PAGE_BC_BIT = 1;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  localparam logic [15:0] CSEL_RESET = 16'h0000;
  localparam logic [15:0] ALL_CH = 16'hFFFF;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [5:0] PAGE_UNUSED = 6'h00;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  localparam logic RW_READ = 1'b1;

  typedef struct packed {
    logic shared;
    logic [NUM_CH-1:0] mask;
    logic [7:0] addr;
    logic [7:0] data;
  } spr_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } spr_state_t;
endpackage : spr_pkg

// *** verilog/spr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module spr_top
  import spr_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // smbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output var logic sda_o,
  output var logic sda_oe_n_o,
  input wire logic [6:0] dev_addr_i,
  // write port to shared and channel register banks
  output var logic wr_stb_o,
  output var spr_wr_t wr_o,
  // read port from register banks
  output var logic [7:0] rd_addr_o,
  output var logic rd_shared_o,
  output var logic [CH_IDX_W-1:0] rd_chan_o,
  input wire logic [7:0] rd_data_i
);

  logic scl_q;
  logic sda_q;
  spr_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic drive_r, drive_nxt;
  logic nack_r, nack_nxt;
  logic [7:0] reg_addr_r, reg_addr_nxt;
  logic [NUM_CH-1:0] csel_r, csel_nxt;
  logic [1:0] page_r, page_nxt;
  logic wr_stb_nxt;
  spr_wr_t wr_nxt;
  logic [CH_IDX_W-1:0] chan_nxt;

  function automatic logic [CH_IDX_W-1:0] chan_index(input logic [NUM_CH-1:0] m);
    logic [CH_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (m[i])
      begin
        idx = CH_IDX_W'(i);
      end
    end
    return idx;
  endfunction : chan_index

  // bus events, pins taken as synchronous
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_det = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_det = scl_i & scl_q & ~sda_q & sda_i;

  wire byte_end = scl_fall & (cnt_r == BYTE_DONE);
  // R16 - address match, lsb is direction
  wire addr_hit = (shift_r[7:1] == dev_addr_i);
  // R1 - write sequence states
  // R2 - ack every byte of a write
  wire ack_now = byte_end & (((state_r == ST_ADDR) & addr_hit) |
                             (state_r == ST_REG) | (state_r == ST_WDATA));
  wire commit = byte_end & (state_r == ST_WDATA);
  // R17 - byte served after our ack or a master ack
  wire load_tx = scl_fall & (cnt_r == ACK_DONE) & (state_r == ST_RDATA) & ~nack_r;

  // R4 - globals decoded ahead of page routing
  wire wr_lo = (reg_addr_r == REG_CSEL_LO);
  wire wr_hi = (reg_addr_r == REG_CSEL_HI);
  wire wr_pg = (reg_addr_r == REG_PAGE);
  wire is_global = wr_lo | wr_hi | wr_pg;

  wire ch_page = page_r[PAGE_CH_BIT];
  wire one_hot = (csel_r != CSEL_RESET) & ((csel_r & (csel_r - NUM_CH'(CNT_ONE))) == CSEL_RESET);
  // R9 - broadcast only with the channel page
  wire bcast = ch_page & page_r[PAGE_BC_BIT];
  // R5 - writes follow the mask
  // R10 - broadcast write while reads use the single selection
  wire [NUM_CH-1:0] wr_mask = bcast ? ALL_CH : csel_r;

  // R7 - multi-select channel read answers zero
  // R11 - unused page bits read zero
  wire [7:0] rd_bank = (ch_page & ~one_hot) ? READ_ZERO : rd_data_i;
  wire [7:0] rd_val = wr_lo ? csel_r[7:0] :
                      wr_hi ? csel_r[15:8] :
                      wr_pg ? {PAGE_UNUSED, page_r} : rd_bank;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    drive_nxt = drive_r;
    nack_nxt = nack_r;
    reg_addr_nxt = reg_addr_r;
    csel_nxt = csel_r;
    page_nxt = page_r;
    wr_stb_nxt = 1'b0;
    wr_nxt = wr_o;
    // repeated start restarts the address phase at any point
    if (start_det)
    begin
      state_nxt = ST_ADDR;
      cnt_nxt = '0;
      drive_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = ST_IDLE;
      cnt_nxt = '0;
      drive_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      if (cnt_r != ACK_DONE)
      begin
        cnt_nxt = cnt_r + CNT_ONE;
      end
      if (cnt_r == BYTE_DONE)
      begin
        nack_nxt = sda_i;
      end
      else if (cnt_r < BYTE_DONE)
      begin
        shift_nxt = {shift_r[6:0], sda_i};
      end
    end
    else if (scl_fall)
    begin
      if (cnt_r == ACK_DONE)
      begin
        cnt_nxt = '0;
        drive_nxt = 1'b0;
        if (state_r == ST_RDATA)
        begin
          if (nack_r)
          begin
            state_nxt = ST_SKIP;
          end
          else
          begin
            tx_nxt = rd_val;
            drive_nxt = ~rd_val[7];
          end
        end
      end
      else if (state_r == ST_RDATA)
      begin
        if (cnt_r != '0)
        begin
          tx_nxt = {tx_r[6:0], 1'b0};
          drive_nxt = (cnt_r != BYTE_DONE) & ~tx_r[6];
        end
      end
      else if (byte_end)
      begin
        drive_nxt = ack_now;
        case (state_r)
          ST_ADDR:
          begin
            state_nxt = ~addr_hit ? ST_SKIP : (shift_r[0] == RW_READ) ? ST_RDATA : ST_REG;
          end
          ST_REG:
          begin
            reg_addr_nxt = shift_r;
            state_nxt = ST_WDATA;
          end
          ST_WDATA:
          begin
            // R3 - config taken whenever addressed
            if (wr_lo)
            begin
              csel_nxt[7:0] = shift_r;
            end
            // R6 - high byte holds channels 15..8
            if (wr_hi)
            begin
              csel_nxt[15:8] = shift_r;
            end
            // R12 - only defined page bits store
            if (wr_pg)
            begin
              page_nxt = shift_r[1:0];
            end
            // R13 - shared versus per-channel target
            // R8 - page bit 0 routes the access
            if (!is_global)
            begin
              wr_stb_nxt = 1'b1;
              wr_nxt.shared = ~ch_page;
              wr_nxt.mask = ch_page ? wr_mask : CSEL_RESET;
              wr_nxt.addr = reg_addr_r;
              wr_nxt.data = shift_r;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_r <= ST_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      drive_r <= 1'b0;
      sda_oe_n_o <= 1'b1;
      nack_r <= 1'b0;
      reg_addr_r <= '0;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      drive_r <= drive_nxt;
      sda_oe_n_o <= ~drive_nxt;
      nack_r <= nack_nxt;
      reg_addr_r <= reg_addr_nxt;
    end
  end

  // R18 - shared page, no channel after reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      csel_r <= CSEL_RESET;
      page_r <= PAGE_RESET;
      wr_stb_o <= 1'b0;
      wr_o <= '0;
      rd_chan_o <= '0;
      rd_shared_o <= 1'b1;
    end
    else
    begin
      csel_r <= csel_nxt;
      page_r <= page_nxt;
      wr_stb_o <= wr_stb_nxt;
      wr_o <= wr_nxt;
      rd_chan_o <= chan_nxt;
      rd_shared_o <= ~page_nxt[PAGE_CH_BIT];
    end
  end

  assign chan_nxt = chan_index(csel_r);
  assign sda_o = 1'b0;
  assign rd_addr_o = reg_addr_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_ACK_DRIVE: assert property (ack_now |=> !sda_oe_n_o [*2]) // R2
    else $error("ack not driven after accepted byte");
  AST_RESET_CLEAR: assert property ($rose(resetn_i) |-> csel_r == CSEL_RESET && page_r == PAGE_RESET) // R18
    else $error("select state not cleared by reset");
  AST_PAGE_READ_ZERO: assert property (load_tx && wr_pg |=> tx_r[7:2] == PAGE_UNUSED) // R11
    else $error("unused page bits read nonzero");
  AST_MULTI_READ: assert property (load_tx && !is_global && ch_page && !one_hot |=> tx_r == READ_ZERO) // R7
    else $error("multi-channel read not zero");
  AST_SINGLE_READ: assert property (load_tx && !is_global && ch_page && one_hot |=> tx_r == $past(rd_data_i)) // R10
    else $error("single channel read data wrong");
  AST_BCAST_ALL: assert property (commit && !is_global && bcast |=> wr_stb_o && wr_o.mask == ALL_CH) // R9
    else $error("broadcast write not to all channels");
  AST_MASK_WRITE: assert property (commit && !is_global && ch_page && !bcast |=> wr_stb_o && wr_o.mask == $past(csel_r)) // R5
    else $error("channel write mask wrong");
  AST_ROUTE: assert property (commit && !is_global |=> wr_o.shared == !$past(ch_page)) // R8
    else $error("page routing wrong");
  AST_GLOBAL_LOCAL: assert property (commit && wr_lo |=> !wr_stb_o && csel_r[7:0] == $past(shift_r)) // R4
    else $error("global write leaked or lost");
  AST_STB_PULSE: assert property (wr_stb_o |=> !wr_stb_o) // R13
    else $error("write strobe longer than a cycle");

  COV_CH_WRITE: cover property (commit && !is_global && ch_page);
  COV_BCAST: cover property (commit && bcast && !is_global);
  COV_MULTI_READ: cover property (load_tx && ch_page && !one_hot);
  COV_SHARED_READ: cover property (load_tx && !ch_page && !is_global);

endmodule : spr_top
`default_nettype wire
